// ### pkg/pin_mux_pkg.sv
// Purpose: shared constants for the operating mode and address pin mux
// Assumes: 8-bit registers on a 32-bit Avalon-MM word, byte addressing
// Notes: register offsets and reset values for control registers are local choices
package pin_mux_pkg;
    localparam int ADDR_W = 24;
    localparam int AREA_CNT = 8;
    localparam int REG_AW = 7;

    // mode pin codes
    localparam logic [2:0] MODE_EXP_1M_ROMOFF = 3'h1;
    localparam logic [2:0] MODE_EXP_16M_ROMOFF = 3'h3;
    localparam logic [2:0] MODE_EXP_1M_ROMON = 3'h5;
    localparam logic [2:0] MODE_EXP_16M_ROMON = 3'h6;
    localparam logic [2:0] MODE_SINGLE = 3'h7;

    // decoded operating mode, one-hot
    typedef enum logic [4:0] {
        OP_SINGLE = 5'h01,
        OP_EXP_1M_OFF = 5'h02,
        OP_EXP_16M_OFF = 5'h04,
        OP_EXP_1M_ON = 5'h08,
        OP_EXP_16M_ON = 5'h10
    } op_mode_e;

    // register slave states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ACK = 2'h2
    } bus_state_e;

    // register byte offsets
    localparam logic [REG_AW-1:0] OFS_P1_DIR = 7'h00;
    localparam logic [REG_AW-1:0] OFS_P2_DIR = 7'h04;
    localparam logic [REG_AW-1:0] OFS_P5_DIR = 7'h08;
    localparam logic [REG_AW-1:0] OFS_PA_DIR = 7'h0C;
    localparam logic [REG_AW-1:0] OFS_BUS_REL = 7'h10;
    localparam logic [REG_AW-1:0] OFS_UPPER_ADDR = 7'h14;
    localparam logic [REG_AW-1:0] OFS_P1_DATA = 7'h18;
    localparam logic [REG_AW-1:0] OFS_P2_DATA = 7'h1C;
    localparam logic [REG_AW-1:0] OFS_P3_DATA = 7'h20;
    localparam logic [REG_AW-1:0] OFS_P3_DIR = 7'h24;
    localparam logic [REG_AW-1:0] OFS_P5_DATA = 7'h28;
    localparam logic [REG_AW-1:0] OFS_PA_DATA = 7'h2C;
    localparam logic [REG_AW-1:0] OFS_MODE_STAT = 7'h30;
    localparam logic [REG_AW-1:0] OFS_P1_PINS = 7'h34;
    localparam logic [REG_AW-1:0] OFS_P2_PINS = 7'h38;
    localparam logic [REG_AW-1:0] OFS_P3_PINS = 7'h3C;
    localparam logic [REG_AW-1:0] OFS_P5A_PINS = 7'h40;

    // reset values and fixed fields
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] UPPER_CTRL_RST = 8'hFF;
    localparam logic [7:0] MODE_STAT_FIXED = 8'hC0;
    localparam int UPPER_EN_LSB = 5;
    localparam int UPPER_EN_MSB = 7;

    // area split: 1-Mbyte space on A19..A17, 16-Mbyte on A23..A21
    localparam int AREA_LSB_1M = 17;
    localparam int AREA_LSB_16M = 21;

    // on-chip RAM and internal I/O windows per address space
    localparam logic [23:0] RAM_LO_1M = 24'h0FEF10;
    localparam logic [23:0] RAM_HI_1M = 24'h0FFF0F;
    localparam logic [23:0] IO_LO_1M = 24'h0FFF1C;
    localparam logic [23:0] IO_HI_1M = 24'h0FFFFF;
    localparam logic [23:0] RAM_LO_16M = 24'hFFEF10;
    localparam logic [23:0] RAM_HI_16M = 24'hFFFF0F;
    localparam logic [23:0] IO_LO_16M = 24'hFFFF1C;
    localparam logic [23:0] IO_HI_16M = 24'hFFFFFF;
    localparam logic [23:0] SPACE_MASK_1M = 24'h0FFFFF;
endpackage : pin_mux_pkg

// ### hw/mode_pin_capture.sv
// Purpose: synchronise the mode pins and hold the mode taken after reset
// Assumes: pins are static while running
// Notes: the held code is loaded once, on the third edge after release
`timescale 1ns/1ns
`default_nettype none
module mode_pin_capture (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [2:0] mode_pins,
    output logic [2:0] pins_live,
    output logic [2:0] mode_held,
    output logic mode_valid
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [1:0] fill_r;

    // two-stage synchroniser, first stage read only by the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
        end else begin
            meta_r <= mode_pins;
            sync_r <= meta_r;
        end
    end

    // load waits until the synchroniser holds real pin levels, not its reset zeros
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_r <= 2'h0;
            mode_held <= 3'h0;
            mode_valid <= 1'b0;
        end else if (fill_r != 2'h2) begin
            fill_r <= fill_r + 2'h1;
        end else if (!mode_valid) begin
            mode_held <= sync_r;
            mode_valid <= 1'b1;
        end
    end

    assign pins_live = sync_r;
endmodule : mode_pin_capture
`default_nettype wire

// ### hw/area_decode.sv
// Purpose: split the address space into areas and find on-chip windows
// Assumes: big_space selects the 16-Mbyte map, else the 1-Mbyte map
// Notes: purely combinational; the caller registers the results
`timescale 1ns/1ns
`default_nettype none
module area_decode
    import pin_mux_pkg::*;
(
    input wire logic [23:0] cpu_addr,
    input wire logic [15:0] abs16,
    input wire logic big_space,
    output logic [AREA_CNT-1:0] area_sel,
    output logic ram_hit,
    output logic io_hit,
    output logic [23:0] abs16_addr
);
    logic [2:0] area_idx;
    logic [23:0] eff_addr;

    // in the 1-Mbyte space the top bits are not decoded
    assign eff_addr = big_space ? cpu_addr : (cpu_addr & SPACE_MASK_1M);
    assign area_idx = big_space ? cpu_addr[AREA_LSB_16M +: 3] : cpu_addr[AREA_LSB_1M +: 3];

    // one select per area
    for (genvar i = 0; i < AREA_CNT; i++) begin : g_area
        assign area_sel[i] = (area_idx == 3'(i));
    end

    // on-chip windows move with the address space size
    assign ram_hit = big_space ? (eff_addr >= RAM_LO_16M && eff_addr <= RAM_HI_16M)
                               : (eff_addr >= RAM_LO_1M && eff_addr <= RAM_HI_1M);
    assign io_hit = big_space ? (eff_addr >= IO_LO_16M && eff_addr <= IO_HI_16M)
                              : (eff_addr >= IO_LO_1M && eff_addr <= IO_HI_1M);

    // short absolute address sign-extends into the top of the active space
    assign abs16_addr = big_space ? {{8{abs16[15]}}, abs16}
                                  : {4'h0, {4{abs16[15]}}, abs16};
endmodule : area_decode
`default_nettype wire

// ### hw/operating_mode_address_pin_mux.sv
// Purpose: operating mode select and port-to-address/data pin mux
// Assumes: one 20 MHz clock, Avalon-MM register slave, byte addresses
// Notes: all pin outputs and enables are registered
`timescale 1ns/1ns
`default_nettype none
module operating_mode_address_pin_mux
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    // Avalon-MM register slave
    input wire logic [REG_AW-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // mode strap pins
    input wire logic [2:0] mode_select_pins,
    // internal bus from the core
    input wire logic [23:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic [15:0] cpu_abs16,
    output logic [7:0] cpu_rdata,
    output logic [AREA_CNT-1:0] area_sel,
    output logic onchip_ram_hit,
    output logic onchip_io_hit,
    output logic [23:0] abs16_addr,
    output logic ext_bus_en,
    output logic [AREA_CNT-1:0] area_byte_access,
    output logic mode_big_space,
    // port pins
    input wire logic [7:0] port1_in,
    output logic [7:0] port1_out,
    output logic [7:0] port1_oe,
    input wire logic [7:0] port2_in,
    output logic [7:0] port2_out,
    output logic [7:0] port2_oe,
    input wire logic [7:0] port3_in,
    output logic [7:0] port3_out,
    output logic [7:0] port3_oe,
    input wire logic [3:0] port5_in,
    output logic [3:0] port5_out,
    output logic [3:0] port5_oe,
    input wire logic [3:0] porta_in,
    output logic [3:0] porta_out,
    output logic [3:0] porta_oe
);

    ////////////////////////////////////////////////////////////////////////
    // mode capture and decode

    logic [2:0] pins_live;
    logic [2:0] mode_held;
    logic mode_valid;
    op_mode_e op_mode;

    mode_pin_capture u_mode (
        .clk(clk),
        .arst_n(arst_n),
        .mode_pins(mode_select_pins),
        .pins_live(pins_live),
        .mode_held(mode_held),
        .mode_valid(mode_valid)
    );

    // unsupported codes fall back to single chip: safe, no pins driven as address or data bus
    always_comb begin
        case (mode_held)
            MODE_EXP_1M_ROMOFF: op_mode = OP_EXP_1M_OFF;
            MODE_EXP_16M_ROMOFF: op_mode = OP_EXP_16M_OFF;
            MODE_EXP_1M_ROMON: op_mode = OP_EXP_1M_ON;
            MODE_EXP_16M_ROMON: op_mode = OP_EXP_16M_ON;
            default: op_mode = OP_SINGLE;
        endcase
    end

    logic expanded;
    logic rom_off;
    logic big_space;

    // mode pins are only trusted once captured
    assign expanded = mode_valid && (op_mode != OP_SINGLE);
    assign rom_off = mode_valid && (op_mode == OP_EXP_1M_OFF || op_mode == OP_EXP_16M_OFF);
    assign big_space = mode_valid && (op_mode == OP_EXP_16M_OFF || op_mode == OP_EXP_16M_ON);

    ////////////////////////////////////////////////////////////////////////
    // pin input synchronisers

    logic [31:0] pin_meta_r;
    logic [31:0] pin_sync_r;
    logic [7:0] p1_pins;
    logic [7:0] p2_pins;
    logic [7:0] p3_pins;
    logic [3:0] p5_pins;
    logic [3:0] pa_pins;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_r <= 32'h0;
            pin_sync_r <= 32'h0;
        end else begin
            pin_meta_r <= {porta_in, port5_in, port3_in, port2_in, port1_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign p1_pins = pin_sync_r[7:0];
    assign p2_pins = pin_sync_r[15:8];
    assign p3_pins = pin_sync_r[23:16];
    assign p5_pins = pin_sync_r[27:24];
    assign pa_pins = pin_sync_r[31:28];

    ////////////////////////////////////////////////////////////////////////
    // register slave

    logic [7:0] p1_dir_r;
    logic [7:0] p2_dir_r;
    logic [3:0] p5_dir_r;
    logic [3:0] pa_dir_r;
    logic [7:0] p3_dir_r;
    logic [7:0] bus_rel_r;
    logic [7:0] upper_ctrl_r;
    logic [7:0] p1_data_r;
    logic [7:0] p2_data_r;
    logic [7:0] p3_data_r;
    logic [3:0] p5_data_r;
    logic [3:0] pa_data_r;
    bus_state_e bus_state_r;
    logic wr_take;
    logic [7:0] rd_val;

    // one wait cycle per access; the write lands on the acknowledging edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_state_r <= BUS_IDLE;
            waitrequest <= 1'b1;
        end else begin
            // low only in the cycle after a request is taken
            waitrequest <= !(bus_state_r == BUS_IDLE && (read || write));
            case (bus_state_r)
                BUS_IDLE: if (read || write) bus_state_r <= BUS_ACK;
                BUS_ACK: bus_state_r <= BUS_IDLE;
                default: bus_state_r <= BUS_IDLE;
            endcase
        end
    end

    assign wr_take = write && (bus_state_r == BUS_ACK);

    // register writes; unmapped offsets are ignored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            p1_dir_r <= DIR_RST;
            p2_dir_r <= DIR_RST;
            p5_dir_r <= DIR_RST[3:0];
            pa_dir_r <= DIR_RST[3:0];
            p3_dir_r <= DIR_RST;
            bus_rel_r <= UPPER_CTRL_RST;
            upper_ctrl_r <= UPPER_CTRL_RST;
            p1_data_r <= DATA_RST;
            p2_data_r <= DATA_RST;
            p3_data_r <= DATA_RST;
            p5_data_r <= DATA_RST[3:0];
            pa_data_r <= DATA_RST[3:0];
        end else if (wr_take) begin
            case ({address[REG_AW-1:2], 2'b00})
                OFS_P1_DIR: p1_dir_r <= writedata[7:0];
                OFS_P2_DIR: p2_dir_r <= writedata[7:0];
                OFS_P5_DIR: p5_dir_r <= writedata[3:0];
                OFS_PA_DIR: pa_dir_r <= writedata[3:0];
                OFS_P3_DIR: p3_dir_r <= writedata[7:0];
                OFS_BUS_REL: bus_rel_r <= writedata[7:0];
                OFS_UPPER_ADDR: upper_ctrl_r <= writedata[7:0];
                OFS_P1_DATA: p1_data_r <= writedata[7:0];
                OFS_P2_DATA: p2_data_r <= writedata[7:0];
                OFS_P3_DATA: p3_data_r <= writedata[7:0];
                OFS_P5_DATA: p5_data_r <= writedata[3:0];
                OFS_PA_DATA: pa_data_r <= writedata[3:0];
                default: ;
            endcase
        end
    end

    // read mux; the mode field shows the live pin levels at read time
    always_comb begin
        case ({address[REG_AW-1:2], 2'b00})
            OFS_P1_DIR: rd_val = p1_dir_r;
            OFS_P2_DIR: rd_val = p2_dir_r;
            OFS_P5_DIR: rd_val = {4'h0, p5_dir_r};
            OFS_PA_DIR: rd_val = {4'h0, pa_dir_r};
            OFS_P3_DIR: rd_val = p3_dir_r;
            OFS_BUS_REL: rd_val = bus_rel_r;
            OFS_UPPER_ADDR: rd_val = upper_ctrl_r;
            OFS_P1_DATA: rd_val = p1_data_r;
            OFS_P2_DATA: rd_val = p2_data_r;
            OFS_P3_DATA: rd_val = p3_data_r;
            OFS_P5_DATA: rd_val = {4'h0, p5_data_r};
            OFS_PA_DATA: rd_val = {4'h0, pa_data_r};
            OFS_MODE_STAT: rd_val = MODE_STAT_FIXED | {5'h00, pins_live};
            OFS_P1_PINS: rd_val = p1_pins;
            OFS_P2_PINS: rd_val = p2_pins;
            OFS_P3_PINS: rd_val = p3_pins;
            OFS_P5A_PINS: rd_val = {pa_pins, p5_pins};
            default: rd_val = 8'h00;
        endcase
    end

    // read data loaded while waiting, steady on the acknowledging edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata <= 32'h0;
        end else if (read && bus_state_r == BUS_IDLE) begin
            readdata <= {24'h0, rd_val};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address pin selection

    logic [7:0] p1_addr_sel;
    logic [7:0] p2_addr_sel;
    logic [3:0] p5_addr_sel;
    logic a20_sel;
    logic [2:0] upper_sel;
    logic [2:0] upper_ctrl_bits;

    // ROM-off modes force address; ROM-on follows each direction bit
    assign p1_addr_sel = !expanded ? 8'h00 : rom_off ? 8'hFF : p1_dir_r;
    assign p2_addr_sel = !expanded ? 8'h00 : rom_off ? 8'hFF : p2_dir_r;
    assign p5_addr_sel = !expanded ? 4'h0 : rom_off ? 4'hF : p5_dir_r;

    // A20 is fixed in the 16-Mbyte modes
    assign a20_sel = big_space;

    // each 16-Mbyte mode has its own enable register; zero enables
    assign upper_ctrl_bits = (op_mode == OP_EXP_16M_OFF) ? bus_rel_r[UPPER_EN_MSB:UPPER_EN_LSB]
                                                         : upper_ctrl_r[UPPER_EN_MSB:UPPER_EN_LSB];
    assign upper_sel = big_space ? ~upper_ctrl_bits : 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // pin drivers

    logic [7:0] p1_out_nxt;
    logic [7:0] p1_oe_nxt;
    logic [7:0] p2_out_nxt;
    logic [7:0] p2_oe_nxt;
    logic [3:0] p5_out_nxt;
    logic [3:0] p5_oe_nxt;
    logic [3:0] pa_out_nxt;
    logic [3:0] pa_oe_nxt;
    logic [7:0] p3_out_nxt;
    logic [7:0] p3_oe_nxt;
    logic [3:0] pa_addr_sel;
    logic [3:0] pa_addr_val;

    assign pa_addr_sel = {a20_sel, upper_sel};
    assign pa_addr_val = {cpu_addr[20], cpu_addr[23:21]};

    // per-bit mux: address when selected, else general port data
    assign p1_out_nxt = (p1_addr_sel & cpu_addr[7:0]) | (~p1_addr_sel & p1_data_r);
    assign p1_oe_nxt = p1_addr_sel | p1_dir_r;
    assign p2_out_nxt = (p2_addr_sel & cpu_addr[15:8]) | (~p2_addr_sel & p2_data_r);
    assign p2_oe_nxt = p2_addr_sel | p2_dir_r;
    assign p5_out_nxt = (p5_addr_sel & cpu_addr[19:16]) | (~p5_addr_sel & p5_data_r);
    assign p5_oe_nxt = p5_addr_sel | p5_dir_r;
    assign pa_out_nxt = (pa_addr_sel & pa_addr_val) | (~pa_addr_sel & pa_data_r);
    assign pa_oe_nxt = pa_addr_sel | pa_dir_r;

    // in expanded modes port 3 is the data bus, driven only on a core write
    assign p3_out_nxt = expanded ? cpu_wdata : p3_data_r;
    assign p3_oe_nxt = expanded ? {8{cpu_wr}} : p3_dir_r;

    // registered pins keep outputs glitch free
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port1_out <= 8'h00;
            port1_oe <= 8'h00;
            port2_out <= 8'h00;
            port2_oe <= 8'h00;
            port5_out <= 4'h0;
            port5_oe <= 4'h0;
            porta_out <= 4'h0;
            porta_oe <= 4'h0;
            port3_out <= 8'h00;
            port3_oe <= 8'h00;
        end else begin
            port1_out <= p1_out_nxt;
            port1_oe <= p1_oe_nxt;
            port2_out <= p2_out_nxt;
            port2_oe <= p2_oe_nxt;
            port5_out <= p5_out_nxt;
            port5_oe <= p5_oe_nxt;
            porta_out <= pa_out_nxt;
            porta_oe <= pa_oe_nxt;
            port3_out <= p3_out_nxt;
            port3_oe <= p3_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // area and on-chip window decode

    logic [AREA_CNT-1:0] area_nxt;
    logic ram_nxt;
    logic io_nxt;
    logic [23:0] abs16_nxt;

    area_decode u_area (
        .cpu_addr(cpu_addr),
        .abs16(cpu_abs16),
        .big_space(big_space),
        .area_sel(area_nxt),
        .ram_hit(ram_nxt),
        .io_hit(io_nxt),
        .abs16_addr(abs16_nxt)
    );

    // decode results and bus status, one cycle behind the core address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            area_sel <= '0;
            onchip_ram_hit <= 1'b0;
            onchip_io_hit <= 1'b0;
            abs16_addr <= 24'h0;
            ext_bus_en <= 1'b0;
            area_byte_access <= '0;
            mode_big_space <= 1'b0;
            cpu_rdata <= 8'h00;
        end else begin
            area_sel <= area_nxt;
            onchip_ram_hit <= ram_nxt;
            onchip_io_hit <= io_nxt;
            abs16_addr <= abs16_nxt;
            ext_bus_en <= expanded;
            // no 16-bit mode exists here, so every area is byte wide in the expanded modes; none is flagged in single chip
            area_byte_access <= {AREA_CNT{expanded}};
            mode_big_space <= big_space;
            cpu_rdata <= p3_pins;
        end
    end

endmodule : operating_mode_address_pin_mux
`default_nettype wire

// ### dv/pin_mux_sva.sv
// Purpose: port-level checks of the mode pin mux
// Assumes: one clock, async active-low reset
// Notes: sees top ports only; bound after endmodule
`timescale 1ns/1ns
`default_nettype none
module pin_mux_sva
    import pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [23:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic [AREA_CNT-1:0] area_sel,
    input wire logic ext_bus_en,
    input wire logic [AREA_CNT-1:0] area_byte_access,
    input wire logic mode_big_space,
    input wire logic [7:0] port1_out,
    input wire logic [7:0] port1_oe,
    input wire logic [7:0] port3_out,
    input wire logic [7:0] port3_oe,
    input wire logic [3:0] porta_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    bus_width_a: assert property (ext_bus_en |-> area_byte_access == 8'hFF)
        else $error("byte access not set in expanded mode");
    single_chip_a: assert property (!ext_bus_en |-> area_byte_access == 8'h00 && !mode_big_space)
        else $error("bus control active without external bus");
    area_split_a: assert property (ext_bus_en && $past(ext_bus_en) |-> area_sel ==
        (8'h01 << (mode_big_space ? $past(cpu_addr[23:21]) : $past(cpu_addr[19:17]))))
        else $error("area select wrong");
    low_addr_a: assert property (ext_bus_en && $past(ext_bus_en) && port1_oe == 8'hFF
        |-> port1_out == $past(cpu_addr[7:0])) else $error("port1 address wrong");
    data_drive_a: assert property (ext_bus_en && $past(ext_bus_en) && $past(cpu_wr)
        |-> port3_oe == 8'hFF && port3_out == $past(cpu_wdata)) else $error("data bus wrong");
    data_release_a: assert property (ext_bus_en && $past(ext_bus_en) && !$past(cpu_wr)
        |-> port3_oe == 8'h00) else $error("data bus driven on read");
    a20_out_a: assert property (mode_big_space |-> porta_oe[3] && ext_bus_en)
        else $error("upper line not driven");
    ack_pulse_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    ack_bound_a: assert property ((read || write) |-> ##[0:2] !waitrequest)
        else $error("no register answer");
    rsvd_zero_a: assert property (readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    cover property (write && !waitrequest);
    cover property (read && !waitrequest);
    cover property (mode_big_space && porta_oe == 4'hF);
endmodule : pin_mux_sva
bind operating_mode_address_pin_mux pin_mux_sva u_sva (.clk, .arst_n, .read, .write, .readdata,
    .waitrequest, .cpu_addr, .cpu_wdata, .cpu_wr, .area_sel, .ext_bus_en, .area_byte_access,
    .mode_big_space, .port1_out, .port1_oe, .port3_out, .port3_oe, .porta_oe);
`default_nettype wire

// ### dv/ext_mem_model.sv
// Purpose: external memory answering on the data bus
// Assumes: byte derived from address lines A19..A0
// Notes: bus input toggles while the device drives so stale data never passes
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
    input wire logic clk,
    input wire logic [7:0] port1_out,
    input wire logic [7:0] port2_out,
    input wire logic [3:0] port5_out,
    input wire logic [7:0] port3_oe,
    output logic [7:0] port3_in
);
    initial port3_in = 8'h00;
    // answer reads, scramble while the device drives
    always @(posedge clk) begin
        if (port3_oe == 8'h00) begin
            port3_in <= port1_out ^ port2_out ^ {4'h0, port5_out} ^ 8'h5A;
        end else begin
            port3_in <= ~port3_in;
        end
    end
endmodule : ext_mem_model
`default_nettype wire

// ### dv/tb.sv
// Purpose: self-checking bench of the mode pin mux
// Assumes: mode pins static through each reset
// Notes: each mode gets a fresh reset; seeded random traffic
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pin_mux_pkg::*;
    logic clk, arst_n, read, write, waitrequest, cpu_wr, ext_bus_en, mode_big_space, big, off;
    logic onchip_ram_hit, onchip_io_hit;
    logic [REG_AW-1:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [2:0] mode_select_pins;
    logic [23:0] cpu_addr, abs16_addr, a;
    logic [15:0] cpu_abs16;
    logic [7:0] cpu_wdata, cpu_rdata, area_sel, area_byte_access, r;
    logic [7:0] port1_in, port1_out, port1_oe, port2_in, port2_out, port2_oe, port3_in, port3_out, port3_oe;
    logic [3:0] port5_in, port5_out, port5_oe, porta_in, porta_out, porta_oe;
    // only supported codes, held through each run
    logic [2:0] modes [5] = '{MODE_EXP_1M_ROMOFF, MODE_EXP_16M_ROMOFF, MODE_EXP_1M_ROMON,
        MODE_EXP_16M_ROMON, MODE_SINGLE};
    int err_count, n_checks, cyc, seed;
    operating_mode_address_pin_mux uut (.clk, .arst_n, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .mode_select_pins, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_abs16, .cpu_rdata,
        .area_sel, .onchip_ram_hit, .onchip_io_hit, .abs16_addr, .ext_bus_en, .area_byte_access,
        .mode_big_space, .port1_in, .port1_out, .port1_oe, .port2_in, .port2_out, .port2_oe,
        .port3_in, .port3_out, .port3_oe, .port5_in, .port5_out, .port5_oe, .porta_in,
        .porta_out, .porta_oe);
    ext_mem_model mem (.clk, .port1_out, .port2_out, .port5_out, .port3_oe, .port3_in);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] mem_byte(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ {4'h0, x[19:16]} ^ 8'h5A;
    endfunction : mem_byte
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [REG_AW-1:0] ad, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= ad;
        writedata <= {24'h0, d};
        read <= !w;
        write <= w;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic drv(input logic [23:0] x, input logic w, input int n);
        @(posedge clk);
        cpu_addr <= x;
        cpu_wr <= w;
        cpu_wdata <= x[23:16];
        cpu_abs16 <= x[23:8];
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : drv
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard, well above the few hundred cycles used
    always @(posedge clk) begin
        cyc++;
        if (cyc > 8000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        {arst_n, read, write, cpu_wr, address, writedata, cpu_addr, cpu_wdata, cpu_abs16} = '0;
        {port1_in, port2_in, port5_in, porta_in} = '0;
        mode_select_pins = MODE_EXP_1M_ROMOFF;
        seed = $urandom(39807);
        for (int m = 0; m < 5; m++) begin
            @(posedge clk);
            mode_select_pins <= modes[m];
            arst_n <= 1'b0;
            {port1_in, port2_in, port5_in, porta_in} <= $urandom;
            repeat (4) @(posedge clk);
            arst_n <= 1'b1;
            repeat (4) @(posedge clk);
            @(negedge clk);
            big = (m == 1 || m == 3);
            off = (m < 2);
            chk("ext_bus_en", m != 4, ext_bus_en);
            chk("big_space", big, mode_big_space);
            chk("byte_access", (m != 4) ? 8'hFF : 8'h00, area_byte_access);
            chk("p1_oe", off ? 8'hFF : 8'h00, port1_oe);
            chk("p5_oe", off ? 4'hF : 4'h0, port5_oe);
            chk("pa_oe", big ? 4'h8 : 4'h0, porta_oe);
            bus(0, OFS_MODE_STAT, 8'h00, rd);
            chk("mode_stat", {24'h0, MODE_STAT_FIXED | {5'h0, modes[m]}}, rd);
            bus(0, OFS_P5A_PINS, 8'h00, rd);
            chk("pins_5a", {porta_in, port5_in}, rd);
            bus(0, OFS_BUS_REL, 8'h00, rd);
            chk("bus_rel", 32'hFF, rd);
            bus(0, 7'h7C, 8'h00, rd);
            chk("unmapped", 32'h0, rd);
            if (big) begin
                bus(1, (m == 1) ? OFS_UPPER_ADDR : OFS_BUS_REL, 8'h00, rd);
                repeat (2) @(negedge clk);
                chk("pa_oe_other", 4'h8, porta_oe);
                bus(1, (m == 1) ? OFS_BUS_REL : OFS_UPPER_ADDR, 8'h1F, rd);
                repeat (2) @(negedge clk);
                chk("pa_oe_upper", 4'hF, porta_oe);
            end
            r = $urandom;
            bus(1, OFS_P1_DIR, r, rd);
            bus(1, OFS_P5_DIR, r, rd);
            repeat (2) @(negedge clk);
            chk("p1_oe_dir", off ? 8'hFF : r, port1_oe);
            if (!off) chk("p5_oe_dir", r[3:0], port5_oe);
            for (int k = 0; k < 8; k++) begin
                a = $urandom;
                drv(a, k[0], 1);
                if (m != 4) chk("area_sel", 8'h01 << (big ? a[23:21] : a[19:17]), area_sel);
                chk("abs16", {{4{big && a[23]}}, {4{a[23]}}, a[23:8]}, abs16_addr);
                if (m == 4) chk("p3_oe_single", 8'h00, port3_oe);
                if (off) chk("addr_lines", a[19:0], {port5_out, port2_out, port1_out});
                if (big) chk("upper_lines", a[23:20], {porta_out[2:0], porta_out[3]});
                if (off && !k[0]) begin
                    repeat (5) @(negedge clk);
                    chk("cpu_rdata", mem_byte(a), cpu_rdata);
                end
            end
            drv(RAM_LO_1M, 1'b0, 1);
            chk("ram_1m", !big, onchip_ram_hit);
            drv(RAM_LO_16M, 1'b0, 1);
            if (big) chk("ram_16m", 1'b1, onchip_ram_hit);
            drv(IO_LO_1M, 1'b0, 1);
            chk("io_1m", !big, onchip_io_hit);
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
